/* src/flpu_top.sv */
// Fractional loop parameter holding and update control
`timescale 1ns/1ps
`default_nettype none
module flpu_top (
    // Clock and reset
    input wire logic clk_in,
    input wire logic resetn_in,
    // Loop control
    input wire logic loop_enable_in,
    input wire logic synchroniser_enable_in,
    input wire logic apply_update_strobe_in,
    // Main path writes
    input wire logic integer_multiplier_wr_in,
    input wire logic [flpu_pkg::INT_W-1:0] integer_multiplier_in,
    input wire logic fraction_numerator_wr_in,
    input wire logic [flpu_pkg::FRAC_W-1:0] fraction_numerator_in,
    input wire logic fraction_denominator_wr_in,
    input wire logic [flpu_pkg::FRAC_W-1:0] fraction_denominator_in,
    input wire logic [flpu_pkg::RATIO_W-1:0] main_ratio_select_in,
    input wire logic [flpu_pkg::GAIN_W-1:0] main_loop_gain_in,
    // Synchroniser path writes
    input wire logic [flpu_pkg::INT_W-1:0] sync_integer_multiplier_in,
    input wire logic [flpu_pkg::FRAC_W-1:0] sync_fraction_numerator_in,
    input wire logic [flpu_pkg::FRAC_W-1:0] sync_fraction_denominator_in,
    input wire logic [flpu_pkg::SRATIO_W-1:0] sync_ratio_select_in,
    input wire logic [flpu_pkg::GAIN_W-1:0] sync_loop_gain_in,
    input wire logic sync_bandwidth_select_in,
    // Readback
    output logic [flpu_pkg::INT_W-1:0] integer_multiplier_out,
    output logic [flpu_pkg::FRAC_W-1:0] fraction_numerator_out,
    output logic apply_update_strobe_out,
    output logic update_pending_out,
    // Values seen by the loop
    output logic [flpu_pkg::INT_W-1:0] loop_integer_out,
    output logic [flpu_pkg::FRAC_W-1:0] loop_numerator_out,
    output logic [flpu_pkg::FRAC_W-1:0] loop_denominator_out,
    output logic loop_fraction_scaled_out,
    output logic [flpu_pkg::RATIO_OUT_W-1:0] loop_main_divide_out,
    output logic [flpu_pkg::GAIN_W-1:0] loop_main_gain_out,
    output logic [flpu_pkg::INT_W-1:0] loop_sync_integer_out,
    output logic [flpu_pkg::FRAC_W-1:0] loop_sync_numerator_out,
    output logic [flpu_pkg::FRAC_W-1:0] loop_sync_denominator_out,
    output logic [flpu_pkg::RATIO_OUT_W-1:0] loop_sync_divide_out,
    output logic [flpu_pkg::GAIN_W-1:0] loop_sync_gain_out,
    output logic loop_sync_narrow_out
);
    // --------------------------------------------------------------
    // Update control
    // --------------------------------------------------------------
    flpu_pkg::flpu_state_t state_reg;
    flpu_pkg::flpu_state_t state_next;
    logic dirty_reg;
    logic dirty_next;
    logic direct;
    logic apply;
    logic any_wr;

    assign direct = !loop_enable_in;
    assign any_wr = integer_multiplier_wr_in || fraction_numerator_wr_in;

    // State and pending flag next values
    always_comb begin
        state_next = state_reg;
        dirty_next = dirty_reg;
        case (state_reg)
            flpu_pkg::FLPU_DIRECT: begin
                // Write in the enable-rise cycle is already held
                dirty_next = loop_enable_in && any_wr;
                if (loop_enable_in) begin
                    state_next = flpu_pkg::FLPU_HOLD;
                end
            end
            flpu_pkg::FLPU_HOLD: begin
                if (any_wr) begin
                    dirty_next = 1'b1;
                end
                if (!loop_enable_in) begin
                    state_next = flpu_pkg::FLPU_DIRECT;
                    dirty_next = 1'b0;
                end else if (apply_update_strobe_in) begin
                    state_next = flpu_pkg::FLPU_APPLY;
                end
            end
            flpu_pkg::FLPU_APPLY: begin
                // Write landing with the transfer stays pending
                dirty_next = any_wr;
                state_next = loop_enable_in ? flpu_pkg::FLPU_HOLD : flpu_pkg::FLPU_DIRECT;
                if (!loop_enable_in) begin
                    dirty_next = 1'b0;
                end
            end
            default: begin
                state_next = flpu_pkg::FLPU_DIRECT;
                dirty_next = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            state_reg <= flpu_pkg::FLPU_DIRECT;
            dirty_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            dirty_reg <= dirty_next;
        end
    end

    // Transfer one cycle after the strobe, only while enabled
    assign apply = (state_reg == flpu_pkg::FLPU_APPLY) && loop_enable_in;
    assign apply_update_strobe_out = 1'b0;
    assign update_pending_out = dirty_reg;

    // --------------------------------------------------------------
    // Staged integer and numerator fields
    // --------------------------------------------------------------
    logic [flpu_pkg::INT_W-1:0] int_active;
    logic [flpu_pkg::FRAC_W-1:0] num_active;

    // Both fields share one apply pulse so they change together
    flpu_field_reg #(.W(flpu_pkg::INT_W), .RESET_VAL(flpu_pkg::INT_RESET)) u_int (
        .clk_in(clk_in),
        .resetn_in(resetn_in),
        .wr_in(integer_multiplier_wr_in),
        .data_in(integer_multiplier_in),
        .direct_in(direct),
        .apply_in(apply),
        .pending_out(integer_multiplier_out),
        .active_out(int_active)
    );

    flpu_field_reg #(.W(flpu_pkg::FRAC_W), .RESET_VAL(flpu_pkg::NUM_RESET)) u_num (
        .clk_in(clk_in),
        .resetn_in(resetn_in),
        .wr_in(fraction_numerator_wr_in),
        .data_in(fraction_numerator_in),
        .direct_in(direct),
        .apply_in(apply),
        .pending_out(fraction_numerator_out),
        .active_out(num_active)
    );

    // --------------------------------------------------------------
    // Denominator, immediate field
    // --------------------------------------------------------------
    logic [flpu_pkg::FRAC_W-1:0] den_reg;
    logic [flpu_pkg::FRAC_W-1:0] den_next;

    always_comb begin
        den_next = fraction_denominator_wr_in ? fraction_denominator_in : den_reg;
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            den_reg <= flpu_pkg::DEN_RESET;
        end else begin
            den_reg <= den_next;
        end
    end

    // --------------------------------------------------------------
    // Ratio decoders
    // --------------------------------------------------------------
    logic [flpu_pkg::RATIO_OUT_W-1:0] main_div;
    logic [flpu_pkg::RATIO_OUT_W-1:0] sync_div;

    // Main ratio is code plus one
    always_comb begin
        main_div = {1'b0, main_ratio_select_in} + flpu_pkg::RATIO_ONE;
    end

    // Sync ratio is a power of two, codes above 4h saturate at 16
    always_comb begin
        if (sync_ratio_select_in >= flpu_pkg::SRATIO_MAX_CODE) begin
            sync_div = flpu_pkg::SRATIO_MAX_DIV;
        end else begin
            sync_div = flpu_pkg::RATIO_ONE << sync_ratio_select_in;
        end
    end

    // --------------------------------------------------------------
    // Registered loop-facing values
    // --------------------------------------------------------------
    logic [flpu_pkg::INT_W-1:0] lint_reg;
    logic [flpu_pkg::FRAC_W-1:0] lnum_reg;
    logic [flpu_pkg::FRAC_W-1:0] lden_reg;
    logic lscaled_reg;
    logic [flpu_pkg::RATIO_OUT_W-1:0] lmdiv_reg;
    logic [flpu_pkg::GAIN_W-1:0] lmgain_reg;
    logic [flpu_pkg::INT_W-1:0] lsint_reg;
    logic [flpu_pkg::FRAC_W-1:0] lsnum_reg;
    logic [flpu_pkg::FRAC_W-1:0] lsden_reg;
    logic [flpu_pkg::RATIO_OUT_W-1:0] lsdiv_reg;
    logic [flpu_pkg::GAIN_W-1:0] lsgain_reg;
    logic lsnarrow_reg;
    logic lscaled_next;
    logic [flpu_pkg::FRAC_W-1:0] lden_next;

    // With sync on the denominator is masked and numerator read as K*65536
    always_comb begin
        lscaled_next = synchroniser_enable_in;
        lden_next = synchroniser_enable_in ? '0 : den_reg;
    end

    // Unsigned integer fields pass straight through
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            lint_reg <= flpu_pkg::INT_RESET;
            lnum_reg <= flpu_pkg::NUM_RESET;
            lden_reg <= flpu_pkg::DEN_RESET;
            lscaled_reg <= 1'b0;
            lmdiv_reg <= flpu_pkg::RATIO_ONE;
            lmgain_reg <= '0;
            lsint_reg <= flpu_pkg::SYNC_INT_RESET;
            lsnum_reg <= flpu_pkg::SYNC_FRAC_RESET;
            lsden_reg <= flpu_pkg::SYNC_FRAC_RESET;
            lsdiv_reg <= flpu_pkg::RATIO_ONE;
            lsgain_reg <= '0;
            lsnarrow_reg <= 1'b0;
        end else begin
            lint_reg <= int_active;
            lnum_reg <= num_active;
            lden_reg <= lden_next;
            lscaled_reg <= lscaled_next;
            lmdiv_reg <= main_div;
            lmgain_reg <= main_loop_gain_in;
            lsint_reg <= sync_integer_multiplier_in;
            lsnum_reg <= sync_fraction_numerator_in;
            lsden_reg <= sync_fraction_denominator_in;
            lsdiv_reg <= sync_div;
            lsgain_reg <= sync_loop_gain_in;
            lsnarrow_reg <= sync_bandwidth_select_in;
        end
    end

    // Output assignments
    assign loop_integer_out = lint_reg;
    assign loop_numerator_out = lnum_reg;
    assign loop_denominator_out = lden_reg;
    assign loop_fraction_scaled_out = lscaled_reg;
    assign loop_main_divide_out = lmdiv_reg;
    assign loop_main_gain_out = lmgain_reg;
    assign loop_sync_integer_out = lsint_reg;
    assign loop_sync_numerator_out = lsnum_reg;
    assign loop_sync_denominator_out = lsden_reg;
    assign loop_sync_divide_out = lsdiv_reg;
    assign loop_sync_gain_out = lsgain_reg;
    assign loop_sync_narrow_out = lsnarrow_reg;
endmodule // flpu_top
`default_nettype wire

/* src/flpu_pkg.sv */
// Constants and types for the fractional loop parameter update block
// Summary of operation
// - While enabled, new multiplier and numerator wait; strobe applies both together.
// - While disabled, multiplier and numerator writes take effect directly.
// - Main ratio code 0h..Fh selects division ratio code plus one.
// - Multiplier, numerator and denominator are plain unsigned integers, LSB weighs one.
// - Sync ratio codes 0h..4h select 1, 2, 4, 8, 16.
// - Sync on in fractional mode: denominator ignored, numerator is fraction times 65536.
// - Apply strobe only acts while the loop is enabled.
package flpu_pkg;
    // --------------------------------------------------------------
    // Field widths
    // --------------------------------------------------------------
    localparam int INT_W = 10;
    localparam int FRAC_W = 16;
    localparam int RATIO_W = 4;
    localparam int SRATIO_W = 3;
    localparam int RATIO_OUT_W = 5;
    localparam int GAIN_W = 4;
    // --------------------------------------------------------------
    // Reset values
    // --------------------------------------------------------------
    localparam logic [9:0] INT_RESET = 10'h008;
    localparam logic [15:0] NUM_RESET = 16'h0018;
    localparam logic [15:0] DEN_RESET = 16'h007D;
    localparam logic [15:0] SYNC_FRAC_RESET = 16'h0000;
    localparam logic [9:0] SYNC_INT_RESET = 10'h000;
    // --------------------------------------------------------------
    // Ratio decoding constants
    // --------------------------------------------------------------
    localparam logic [4:0] RATIO_ONE = 5'h01;
    localparam logic [2:0] SRATIO_MAX_CODE = 3'h4;
    localparam logic [4:0] SRATIO_MAX_DIV = 5'h10;
    // Update engine states
    typedef enum logic [1:0] {
        FLPU_DIRECT = 2'b00,
        FLPU_HOLD = 2'b01,
        FLPU_APPLY = 2'b11
    } flpu_state_t;
endpackage : flpu_pkg

/* src/flpu_field_reg.sv */
// Staged parameter field with pending and active copies
`timescale 1ns/1ps
`default_nettype none
module flpu_field_reg #(
    parameter int W = 16,
    parameter logic [W-1:0] RESET_VAL = '0
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic resetn_in,
    // Write side
    input wire logic wr_in,
    input wire logic [W-1:0] data_in,
    input wire logic direct_in,
    input wire logic apply_in,
    // Values
    output logic [W-1:0] pending_out,
    output logic [W-1:0] active_out
);
    logic [W-1:0] pend_reg;
    logic [W-1:0] pend_next;
    logic [W-1:0] act_reg;
    logic [W-1:0] act_next;

    // Refuse widths the staged copies cannot hold
    if (W < 1) begin : g_bad_width
        $error("field width must be at least one");
    end

    // Next pending and active copies
    always_comb begin
        pend_next = wr_in ? data_in : pend_reg;
        act_next = act_reg;
        if (apply_in) begin
            act_next = pend_reg;
        end
        if (direct_in && wr_in) begin
            act_next = data_in;
        end
    end

    // Registers
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            pend_reg <= RESET_VAL;
            act_reg <= RESET_VAL;
        end else begin
            pend_reg <= pend_next;
            act_reg <= act_next;
        end
    end

    assign pending_out = pend_reg;
    assign active_out = act_reg;
endmodule // flpu_field_reg
`default_nettype wire

/* bench/flpu_monitor.sv */
// Assertion checker for the loop parameter update block
`timescale 1ns/1ps
`default_nettype none
module flpu_monitor (
    // Clock and reset
    input wire logic clk_in,
    input wire logic resetn_in,
    // Watched inputs
    input wire logic loop_enable_in,
    input wire logic synchroniser_enable_in,
    input wire logic apply_update_strobe_in,
    input wire logic integer_multiplier_wr_in,
    input wire logic [9:0] integer_multiplier_in,
    input wire logic [3:0] main_ratio_select_in,
    input wire logic [2:0] sync_ratio_select_in,
    // Watched outputs
    input wire logic [9:0] integer_multiplier_out,
    input wire logic apply_update_strobe_out,
    input wire logic update_pending_out,
    input wire logic [9:0] loop_integer_out,
    input wire logic [15:0] loop_numerator_out,
    input wire logic [15:0] loop_denominator_out,
    input wire logic loop_fraction_scaled_out,
    input wire logic [4:0] loop_main_divide_out,
    input wire logic [4:0] loop_sync_divide_out
);
    // ------------------------------------------------------------
    // Cycles spent with the loop enabled, saturating at seven
    // ------------------------------------------------------------
    logic [2:0] en_cnt_reg;
    logic [2:0] en_cnt_next;
    always_comb begin
        en_cnt_next = (en_cnt_reg == 3'h7) ? 3'h7 : en_cnt_reg + 3'h1;
        if (!loop_enable_in) begin
            en_cnt_next = 3'h0;
        end
    end
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            en_cnt_reg <= 3'h0;
        end else begin
            en_cnt_reg <= en_cnt_next;
        end
    end
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!resetn_in);
    // Direct write followed by one quiet disabled cycle
    sequence s_direct_write;
        !loop_enable_in && integer_multiplier_wr_in ##1 !loop_enable_in && !integer_multiplier_wr_in;
    endsequence
    a_strobe_reads_zero: assert property (apply_update_strobe_out == 1'b0)
        else $error("strobe readback not zero");
    a_direct_write_lands: assert property (s_direct_write |-> ##1 loop_integer_out == $past(integer_multiplier_in, 2))
        else $error("direct write did not reach loop");
    a_hold_until_apply: assert property (($changed(loop_integer_out) || $changed(loop_numerator_out))
        && en_cnt_reg > 3'h5 |-> $past(apply_update_strobe_in, 1) || $past(apply_update_strobe_in, 2)
        || $past(apply_update_strobe_in, 3) || $past(apply_update_strobe_in, 4) || $past(apply_update_strobe_in, 5))
        else $error("loop value changed without strobe");
    a_pending_drops: assert property (!loop_enable_in |=> !update_pending_out)
        else $error("pending flag while disabled");
    a_readback_write: assert property (integer_multiplier_wr_in |=> integer_multiplier_out == $past(integer_multiplier_in))
        else $error("readback differs from write");
    a_main_divide_map: assert property ($past(resetn_in) |-> loop_main_divide_out == 5'h01 + $past(main_ratio_select_in))
        else $error("main divide wrong");
    a_sync_divide_map: assert property ($past(resetn_in) |-> loop_sync_divide_out ==
        (($past(sync_ratio_select_in) > 3'h3) ? 5'h10 : (5'h01 << $past(sync_ratio_select_in))))
        else $error("sync divide wrong");
    a_sync_ignores_den: assert property ($past(resetn_in) |->
        loop_fraction_scaled_out == $past(synchroniser_enable_in)
        && (!$past(synchroniser_enable_in) || loop_denominator_out == 16'h0000))
        else $error("denominator not ignored");
endmodule // flpu_monitor
bind flpu_top flpu_monitor u_monitor (.*);
`default_nettype wire

/* bench/flpu_host_model.sv */
// Host software model that writes the staged loop fields
`timescale 1ns/1ps
`default_nettype none
module flpu_host_model (
    // Clock
    input wire logic clk_in,
    // Field writes
    output var logic integer_multiplier_wr_in,
    output var logic [9:0] integer_multiplier_in,
    output var logic fraction_numerator_wr_in,
    output var logic [15:0] fraction_numerator_in,
    output var logic fraction_denominator_wr_in,
    output var logic [15:0] fraction_denominator_in,
    output var logic apply_update_strobe_in
);
    // Idle bus at time zero
    initial begin
        integer_multiplier_wr_in = 1'b0;
        integer_multiplier_in = 10'h000;
        fraction_numerator_wr_in = 1'b0;
        fraction_numerator_in = 16'h0000;
        fraction_denominator_wr_in = 1'b0;
        fraction_denominator_in = 16'h0000;
        apply_update_strobe_in = 1'b0;
    end
    // Both fields in one cycle; released data is scrambled
    task automatic write_pair(input logic [9:0] n, input logic [15:0] k);
        @(negedge clk_in);
        integer_multiplier_in = n;
        fraction_numerator_in = k;
        integer_multiplier_wr_in = 1'b1;
        fraction_numerator_wr_in = 1'b1;
        @(negedge clk_in);
        integer_multiplier_wr_in = 1'b0;
        fraction_numerator_wr_in = 1'b0;
        integer_multiplier_in = ~n;
        fraction_numerator_in = ~k;
    endtask
    // Denominator write, reduced by the caller
    task automatic write_den(input logic [15:0] d);
        @(negedge clk_in);
        fraction_denominator_in = d;
        fraction_denominator_wr_in = 1'b1;
        @(negedge clk_in);
        fraction_denominator_wr_in = 1'b0;
        fraction_denominator_in = ~d;
    endtask
    // One-cycle write of one to the apply strobe
    task automatic apply_update();
        @(negedge clk_in);
        apply_update_strobe_in = 1'b1;
        @(negedge clk_in);
        apply_update_strobe_in = 1'b0;
    endtask
endmodule // flpu_host_model
`default_nettype wire

/* bench/testbench.sv */
// Self-checking testbench for the loop parameter update block
`timescale 1ns/1ps
`default_nettype none
`define CHECK(nm, exp, got) begin \
    check_count++; \
    if ((got) !== (exp)) begin \
        failures++; \
        $display("unexpected %s expected %0h seen %0h", nm, (exp), (got)); \
    end \
end
module testbench;
    logic clk_in, integer_multiplier_wr_in, fraction_numerator_wr_in, fraction_denominator_wr_in;
    logic resetn_in = 1'b0, loop_enable_in = 1'b0, synchroniser_enable_in = 1'b0, sync_bandwidth_select_in = 1'b0;
    logic apply_update_strobe_in, apply_update_strobe_out, update_pending_out;
    logic loop_fraction_scaled_out, loop_sync_narrow_out;
    logic [9:0] integer_multiplier_in, integer_multiplier_out, loop_integer_out, loop_sync_integer_out;
    logic [9:0] sync_integer_multiplier_in = 10'h000;
    logic [15:0] fraction_numerator_in, fraction_denominator_in, sync_fraction_numerator_in = 16'h0000;
    logic [15:0] sync_fraction_denominator_in = 16'h0000, fraction_numerator_out, loop_numerator_out;
    logic [15:0] loop_denominator_out, loop_sync_numerator_out, loop_sync_denominator_out;
    logic [3:0] main_ratio_select_in = 4'h0, main_loop_gain_in = 4'h0, sync_loop_gain_in = 4'h0;
    logic [3:0] loop_main_gain_out, loop_sync_gain_out;
    logic [2:0] sync_ratio_select_in = 3'h0;
    logic [4:0] loop_main_divide_out, loop_sync_divide_out;
    int failures = 0;
    int check_count = 0;
    flpu_top DUT (.*);
    flpu_host_model HOST (.*);
    // 10 MHz clock
    initial begin
        clk_in = 1'b0;
        forever #50 clk_in = ~clk_in;
    end
    task automatic cycles(input int n);
        repeat (n) @(negedge clk_in);
    endtask
    task automatic test_done();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // Values after reset
    task automatic t_reset();
        `CHECK("integer", 10'h008, loop_integer_out)
        `CHECK("numerator", 16'h0018, loop_numerator_out)
        `CHECK("denominator", 16'h007D, loop_denominator_out)
    endtask
    // Disabled loop takes writes at once
    task automatic t_direct();
        HOST.write_pair(10'h1F3, 16'h0007);
        cycles(2);
        `CHECK("direct int", 10'h1F3, loop_integer_out)
        `CHECK("direct num", 16'h0007, loop_numerator_out)
        `CHECK("readback", 10'h1F3, integer_multiplier_out)
        `CHECK("num readback", 16'h0007, fraction_numerator_out)
    endtask
    // Enabled loop holds writes until the strobe, then ignores a disabled strobe
    task automatic t_staged();
        loop_enable_in = 1'b1;
        cycles(3);
        HOST.write_pair(10'h0A5, 16'h0011);
        cycles(3);
        `CHECK("held int", 10'h1F3, loop_integer_out)
        `CHECK("held num", 16'h0007, loop_numerator_out)
        `CHECK("pending", 1'b1, update_pending_out)
        HOST.apply_update();
        `CHECK("strobe readback", 1'b0, apply_update_strobe_out)
        cycles(5);
        `CHECK("applied int", 10'h0A5, loop_integer_out)
        `CHECK("applied num", 16'h0011, loop_numerator_out)
        `CHECK("pending clear", 1'b0, update_pending_out)
        HOST.write_pair(10'h3FF, 16'h0013);
        loop_enable_in = 1'b0;
        cycles(2);
        HOST.apply_update();
        cycles(4);
        `CHECK("ignored int", 10'h0A5, loop_integer_out)
        `CHECK("ignored num", 16'h0011, loop_numerator_out)
    endtask
    // Every ratio code of both paths
    task automatic t_ratio();
        for (int c = 0; c < 16; c++) begin
            main_ratio_select_in = c[3:0];
            cycles(2);
            `CHECK("main divide", 5'(c + 1), loop_main_divide_out)
        end
        for (int c = 0; c < 8; c++) begin
            sync_ratio_select_in = c[2:0];
            cycles(2);
            `CHECK("sync divide", (c > 3) ? 5'h10 : 5'(1 << c), loop_sync_divide_out)
        end
    endtask
    // Synchroniser on: denominator ignored, sync fields passed through
    task automatic t_sync();
        HOST.write_den(16'h0123);
        synchroniser_enable_in = 1'b1;
        // 11.2896 MHz sync input at ratio 1 for a 98.304 MHz loop
        sync_ratio_select_in = 3'h0;
        sync_integer_multiplier_in = 10'h008;
        sync_fraction_numerator_in = 16'h0068;
        sync_fraction_denominator_in = 16'h0093;
        sync_loop_gain_in = 4'h4;
        sync_bandwidth_select_in = 1'b0;
        main_loop_gain_in = 4'h2;
        cycles(2);
        `CHECK("den ignored", 16'h0000, loop_denominator_out)
        `CHECK("scaled", 1'b1, loop_fraction_scaled_out)
        `CHECK("sync int", 10'h008, loop_sync_integer_out)
        `CHECK("sync num", 16'h0068, loop_sync_numerator_out)
        `CHECK("sync den", 16'h0093, loop_sync_denominator_out)
        `CHECK("sync gain", 4'h4, loop_sync_gain_out)
        `CHECK("wide", 1'b0, loop_sync_narrow_out)
        `CHECK("main gain", 4'h2, loop_main_gain_out)
        synchroniser_enable_in = 1'b0;
        // Move to the 64 kHz to 128 kHz band
        sync_ratio_select_in = 3'h3;
        sync_loop_gain_in = 4'h0;
        sync_bandwidth_select_in = 1'b1;
        cycles(2);
        `CHECK("den back", 16'h0123, loop_denominator_out)
        `CHECK("unscaled", 1'b0, loop_fraction_scaled_out)
        `CHECK("narrow", 1'b1, loop_sync_narrow_out)
        `CHECK("sync gain low", 4'h0, loop_sync_gain_out)
        `CHECK("sync divide 8", 5'h08, loop_sync_divide_out)
    endtask
    // Watchdog
    initial begin
        #(2000 * 100);
        failures++;
        test_done();
    end
    // Main sequence
    initial begin
        cycles(16);
        resetn_in = 1'b1;
        cycles(1);
        t_reset();
        t_direct();
        t_staged();
        t_ratio();
        t_sync();
        test_done();
    end
endmodule // testbench
`default_nettype wire
